/* rtl/rjlc_disp.sv */
`timescale 1ns/1ps
module rjlc_disp (
   rjlc_disp_if.calc dif
);
   import rjlc_pkg::*;

   // ***************************************************************
   // displacement forming
   // ***************************************************************
   function automatic logic [DATA_W-1:0] rotr8(input logic [DATA_W-1:0] v, input logic [2:0] b);
      logic [2*DATA_W-1:0] dbl;
      dbl = {v, v} >> b;
      rotr8 = dbl[DATA_W-1:0];
   endfunction

   logic [DATA_W-1:0] rot_copy;
   logic [DATA_W-1:0] masked;

   // RULE_06: rotate temporary copy
   // RULE_07: zero count no rotate
   assign rot_copy = rotr8(dif.src, dif.rot);
   // RULE_08: clear top and lsb
   assign masked = rot_copy & (8'hFF >> dif.mask) & 8'hFE;

   always_comb begin
      case (dif.mode)
         // RULE_01: sign extend immediate
         DM_IMM: dif.disp = sext8(dif.imm);
         // RULE_02: sign extend register
         DM_REG: dif.disp = sext8(dif.src);
         // RULE_09: even table entries
         DM_RMK: dif.disp = sext8(masked);
         default: dif.disp = '0;
      endcase
   end

endmodule // rjlc_disp

/* rtl/rjlc_disp_if.sv */
`timescale 1ns/1ps
interface rjlc_disp_if;
   import rjlc_pkg::*;
   rjlc_dmode_e mode;
   logic [DATA_W-1:0] imm;
   logic [DATA_W-1:0] src;
   logic [2:0] rot;
   logic [2:0] mask;
   logic [ADDR_W-1:0] disp;
   modport core (output mode, output imm, output src, output rot, output mask, input disp);
   modport calc (input mode, input imm, input src, input rot, input mask, output disp);
endinterface

/* rtl/rjlc_pkg.sv */
package rjlc_pkg;

   // ***************************************************************
   // widths
   // ***************************************************************
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int SRC_W = 5;
   localparam int FLAG_W = 4;
   localparam int FRAME_W = ADDR_W + FLAG_W + 3;

   // ***************************************************************
   // opcodes and field positions
   // ***************************************************************
   localparam logic [7:0] OP_RELJ_IMM = 8'hCB;
   localparam logic [7:0] OP_RELJ_REG = 8'hCD;
   localparam logic [2:0] OP_RELJ_REG_SUB = 3'h4;
   localparam logic [15:0] OP_CALL_ABS = 16'hCE00;
   localparam logic [4:0] OP_ROTJ = 5'h13;
   localparam logic [6:0] OP_CALL_BIT = 7'h44;
   localparam int SRC_LSB = 0;
   localparam int SUB_LSB = 5;
   localparam int B_LSB = 5;
   localparam int M_LSB = 8;
   localparam int P_LSB = 5;
   localparam int S_BIT = 8;
   localparam int IMM_LSB = 0;

   // ***************************************************************
   // clock states per instruction
   // ***************************************************************
   localparam logic [2:0] TS_RELJ_IMM = 3'h3;
   localparam logic [2:0] TS_RELJ_REG = 3'h4;
   localparam logic [2:0] TS_ROTJ = 3'h4;
   localparam logic [2:0] TS_CALL = 3'h4;
   localparam logic [ADDR_W-1:0] CALL_WORDS = 16'h0001;

   // ***************************************************************
   // types
   // ***************************************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_FETCH = 2'h1,
      ST_CAPT = 2'h3,
      ST_FINISH = 2'h2
   } rjlc_state_e;

   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_JIMM = 3'h1,
      OP_JREG = 3'h2,
      OP_RMK = 3'h3,
      OP_CALL = 3'h4,
      OP_CALLB = 3'h5
   } rjlc_op_e;

   typedef enum logic [1:0] {
      DM_IMM = 2'h0,
      DM_REG = 2'h1,
      DM_RMK = 2'h2
   } rjlc_dmode_e;

   typedef struct packed {
      rjlc_state_e state;
      rjlc_op_e op;
      logic [15:0] instr;
      logic [ADDR_W-1:0] pc;
      logic [DATA_W-1:0] rdata;
      logic [ADDR_W-1:0] word2;
      logic busy;
      logic [SRC_W-1:0] reg_sel;
      logic reg_rd;
      logic word2_req;
      logic [ADDR_W-1:0] word2_addr;
      logic pc_load;
      logic [ADDR_W-1:0] pc_out;
      logic stack_push;
      logic [FRAME_W-1:0] frame;
      logic illegal;
   } rjlc_st_s;

   localparam rjlc_st_s ST_RESET = '0;

   // ***************************************************************
   // helpers
   // ***************************************************************
   function automatic logic [ADDR_W-1:0] sext8(input logic [DATA_W-1:0] v);
      sext8 = {{(ADDR_W-DATA_W){v[DATA_W-1]}}, v};
   endfunction

endpackage

/* rtl/rjlc_unit.sv */
`timescale 1ns/1ps
// How it works
// RULE_01: immediate jump adds sign-extended 8-bit displacement to the program counter.
// RULE_02: register jump adds sign-extended byte of any active register.
// RULE_03: displacement base is the address after the jump, reach +127/-128.
// RULE_04: immediate jump decoded from upper byte 11001011, displacement low byte.
// RULE_05: immediate jump takes three states, register jump four.
// RULE_06: rotate-mask jump rotates a copy right by b, source untouched.
// RULE_07: rotate count 0 to 7, zero means no rotation.
// RULE_08: rotated copy loses top m bits and bit 0, then sign-extends.
// RULE_09: cleared bit 0 gives two-word table entries, reach +126/-128.
// RULE_10: rotate-mask base is next instruction address, any active register.
// RULE_11: conditional call proceeds only when register bit p equals s.
// RULE_12: taken conditional call pushes pc, flags, interrupt enable, banks.
// RULE_13: call target is a 16-bit absolute address loaded into pc.
// RULE_14: unconditional call always pushes return state then loads target.
// RULE_15: failed conditional call pushes nothing, continues after both words.
// RULE_16: none of these instructions write the ALU flags.
// RULE_17: saved bank selection holds separate low and high bank choices.
// RULE_18: unconditional call takes two plus two states.
module rjlc_unit #(
   parameter int PC_W = 16
) (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic start_i,
   input wire logic [15:0] instr_i,
   input wire logic [rjlc_pkg::ADDR_W-1:0] next_pc_i,
   input wire logic [rjlc_pkg::DATA_W-1:0] reg_data_i,
   input wire logic [rjlc_pkg::ADDR_W-1:0] word2_i,
   input wire logic [rjlc_pkg::FLAG_W-1:0] alu_flags_i,
   input wire logic global_interrupt_enable_i,
   input wire logic bank_a_alt_i,
   input wire logic bank_b_alt_i,
   output logic busy_o,
   output logic [rjlc_pkg::SRC_W-1:0] reg_sel_o,
   output logic reg_rd_o,
   output logic word2_req_o,
   output logic [rjlc_pkg::ADDR_W-1:0] word2_addr_o,
   output logic pc_load_o,
   output logic [rjlc_pkg::ADDR_W-1:0] pc_o,
   output logic stack_push_o,
   output logic [rjlc_pkg::FRAME_W-1:0] stack_frame_o,
   output logic flags_we_o,
   output logic illegal_o
);
   import rjlc_pkg::*;

   // ***************************************************************
   // parameter check
   // ***************************************************************
   if (PC_W != ADDR_W) begin : g_bad_width
      $error("rjlc_unit: program counter width must be 16");
   end

   // ***************************************************************
   // decoding
   // ***************************************************************
   function automatic rjlc_op_e decode(input logic [15:0] w);
      // RULE_04: immediate jump opcode
      if (w[15:8] == OP_RELJ_IMM) begin
         decode = OP_JIMM;
      end else if (w[15:8] == OP_RELJ_REG && w[SUB_LSB +: 3] == OP_RELJ_REG_SUB) begin
         decode = OP_JREG;
      end else if (w == OP_CALL_ABS) begin
         decode = OP_CALL;
      end else if (w[15:11] == OP_ROTJ) begin
         decode = OP_RMK;
      end else if (w[15:9] == OP_CALL_BIT) begin
         decode = OP_CALLB;
      end else begin
         decode = OP_NONE;
      end
   endfunction

   function automatic logic [2:0] ts_of(input rjlc_op_e op);
      case (op)
         OP_JIMM: ts_of = TS_RELJ_IMM;
         OP_JREG: ts_of = TS_RELJ_REG;
         OP_RMK: ts_of = TS_ROTJ;
         // RULE_18: calls four states
         default: ts_of = TS_CALL;
      endcase
   endfunction

   function automatic logic uses_reg(input rjlc_op_e op);
      uses_reg = (op == OP_JREG) || (op == OP_RMK) || (op == OP_CALLB);
   endfunction

   function automatic logic is_call(input rjlc_op_e op);
      is_call = (op == OP_CALL) || (op == OP_CALLB);
   endfunction

   // ***************************************************************
   // state and displacement unit
   // ***************************************************************
   rjlc_st_s st;
   rjlc_st_s next_st;
   rjlc_op_e in_op;
   logic bit_hit;
   logic [ADDR_W-1:0] ret_pc;
   logic [1:0] banks_in;
   rjlc_disp_if dif ();

   rjlc_disp u_disp (
      .dif(dif.calc)
   );

   assign in_op = decode(instr_i);
   assign banks_in = {bank_a_alt_i, bank_b_alt_i};
   assign ret_pc = st.pc + CALL_WORDS;
   // RULE_11: bit p against state s
   assign bit_hit = (st.rdata[st.instr[P_LSB +: 3]] == st.instr[S_BIT]);

   always_comb begin
      case (st.op)
         OP_JREG: dif.mode = DM_REG;
         OP_RMK: dif.mode = DM_RMK;
         default: dif.mode = DM_IMM;
      endcase
   end
   assign dif.imm = st.instr[IMM_LSB +: DATA_W];
   // RULE_10: any active register source
   assign dif.src = st.rdata;
   assign dif.rot = st.instr[B_LSB +: 3];
   assign dif.mask = st.instr[M_LSB +: 3];

   // ***************************************************************
   // sequencing
   // ***************************************************************
   always_comb begin
      next_st = st;
      next_st.pc_load = 1'b0;
      next_st.stack_push = 1'b0;
      next_st.reg_rd = 1'b0;
      next_st.word2_req = 1'b0;
      next_st.illegal = 1'b0;
      case (st.state)
         ST_IDLE: begin
            if (start_i) begin
               next_st.op = in_op;
               next_st.instr = instr_i;
               // RULE_03: base is following address
               next_st.pc = next_pc_i;
               if (in_op == OP_NONE) begin
                  next_st.illegal = 1'b1;
               end else begin
                  next_st.state = ST_FETCH;
                  next_st.busy = 1'b1;
                  next_st.reg_sel = instr_i[SRC_LSB +: SRC_W];
                  next_st.reg_rd = uses_reg(in_op);
                  next_st.word2_req = is_call(in_op);
                  next_st.word2_addr = next_pc_i;
               end
            end
         end
         ST_FETCH: begin
            next_st.state = ST_CAPT;
         end
         ST_CAPT: begin
            next_st.rdata = reg_data_i;
            next_st.word2 = word2_i;
            // RULE_05: three state immediate jump
            if (ts_of(st.op) == TS_RELJ_IMM) begin
               next_st.pc_load = 1'b1;
               next_st.pc_out = st.pc + dif.disp;
               next_st.state = ST_IDLE;
               next_st.busy = 1'b0;
            end else begin
               next_st.state = ST_FINISH;
            end
         end
         ST_FINISH: begin
            next_st.state = ST_IDLE;
            next_st.busy = 1'b0;
            next_st.pc_load = 1'b1;
            case (st.op)
               OP_JREG, OP_RMK: begin
                  next_st.pc_out = st.pc + dif.disp;
               end
               OP_CALL: begin
                  // RULE_14: unconditional push
                  // RULE_17: two bank choices saved
                  next_st.stack_push = 1'b1;
                  next_st.frame = {ret_pc, alu_flags_i, global_interrupt_enable_i, banks_in};
                  // RULE_13: absolute target
                  next_st.pc_out = st.word2;
               end
               OP_CALLB: begin
                  if (bit_hit) begin
                     // RULE_12: push on match
                     next_st.stack_push = 1'b1;
                     next_st.frame = {ret_pc, alu_flags_i, global_interrupt_enable_i, banks_in};
                     next_st.pc_out = st.word2;
                  end else begin
                     // RULE_15: skip both words
                     next_st.pc_out = ret_pc;
                  end
               end
               default: begin
                  next_st.pc_out = st.pc;
               end
            endcase
         end
         default: begin
            next_st = ST_RESET;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign busy_o = st.busy;
   assign reg_sel_o = st.reg_sel;
   assign reg_rd_o = st.reg_rd;
   assign word2_req_o = st.word2_req;
   assign word2_addr_o = st.word2_addr;
   assign pc_load_o = st.pc_load;
   assign pc_o = st.pc_out;
   assign stack_push_o = st.stack_push;
   assign stack_frame_o = st.frame;
   // RULE_16: flags never written
   assign flags_we_o = 1'b0;
   assign illegal_o = st.illegal;

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   logic [DATA_W-1:0] imm_byte;
   logic [SRC_W-1:0] src_field;
   logic idle_start;
   assign imm_byte = instr_i[IMM_LSB +: DATA_W];
   assign src_field = instr_i[SRC_LSB +: SRC_W];
   assign idle_start = (st.state == ST_IDLE) && start_i;

   sequence s_imm_start;
      idle_start && (in_op == OP_JIMM);
   endsequence

   sequence s_four_start;
      idle_start && (in_op == OP_JREG || in_op == OP_RMK || in_op == OP_CALL);
   endsequence

   sequence s_call_start;
      idle_start && (in_op == OP_CALL);
   endsequence

   sequence s_reg_fetch;
      reg_rd_o ##1 !reg_rd_o;
   endsequence

   sequence s_bad_start;
      idle_start && (in_op == OP_NONE);
   endsequence

   // RULE_05: three state timing
   a_imm_timing: assert property (s_imm_start |=> !pc_load_o [*2] ##1 pc_load_o) // RULE_05
      else $error("immediate jump not done in three states");
   // RULE_01: immediate target value
   a_imm_target: assert property (s_imm_start |-> ##3 pc_o == $past(next_pc_i, 3) + sext8($past(imm_byte, 3))) // RULE_01
      else $error("immediate jump target wrong");
   // RULE_18: four state timing
   a_four_timing: assert property (s_four_start |=> !pc_load_o [*3] ##1 pc_load_o) // RULE_18
      else $error("four state instruction timing wrong");
   // RULE_02: register read ahead
   a_reg_fetch: assert property (idle_start && uses_reg(in_op) |=> s_reg_fetch) // RULE_02
      else $error("register operand not requested");
   // RULE_09: even rotate mask displacement
   a_rmk_even: assert property (st.state == ST_FINISH && st.op == OP_RMK |-> dif.disp[0] == 1'b0) // RULE_09
      else $error("rotate mask displacement odd");
   // RULE_13: call loads second word
   a_call_target: assert property (s_call_start |-> ##4 stack_push_o && pc_o == $past(word2_i, 2)) // RULE_13
      else $error("call target not the second word");
   // RULE_15: failed test pushes nothing
   a_fail_nopush: assert property (st.state == ST_FINISH && st.op == OP_CALLB && !bit_hit
      |=> pc_load_o && !stack_push_o && pc_o == $past(ret_pc)) // RULE_15
      else $error("failed call pushed or branched");
   // RULE_17: banks in frame
   a_bank_saved: assert property (stack_push_o |-> stack_frame_o[1:0] == $past(banks_in) && pc_load_o) // RULE_17
      else $error("bank selection not saved");
   // RULE_16: flags left alone
   a_flags_kept: assert property (busy_o |-> !flags_we_o) // RULE_16
      else $error("flags written");
   // RULE_08: mask clears sign bit
   a_rmk_top: assert property (st.state == ST_FINISH && st.op == OP_RMK && st.instr[M_LSB +: 3] != 3'h0 |-> !dif.disp[ADDR_W-1]) // RULE_08
      else $error("rotate mask top bits not cleared");
   // RULE_12: taken call pushes and branches
   a_push_match: assert property (st.state == ST_FINISH && st.op == OP_CALLB && bit_hit |=> stack_push_o && pc_load_o && pc_o == st.word2) // RULE_12
      else $error("taken call did not push or branch");
   // RULE_04: unknown opcode stays idle
   a_illegal_quiet: assert property (s_bad_start |=> illegal_o && !busy_o && !pc_load_o) // RULE_04
      else $error("unknown opcode started work");
   // RULE_02: register select from instruction
   a_src_select: assert property (idle_start && uses_reg(in_op) |=> reg_sel_o == $past(src_field)) // RULE_02
      else $error("register select wrong");

endmodule // rjlc_unit

/* sim/rjlc_far.sv */
`timescale 1ns/1ps
// ***************************************************************
// far side: register file, second-word memory, address stack
// ***************************************************************
module rjlc_far (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic [rjlc_pkg::SRC_W-1:0] reg_sel_i,
   input wire logic reg_rd_i,
   input wire logic word2_req_i,
   input wire logic [rjlc_pkg::ADDR_W-1:0] word2_addr_i,
   input wire logic stack_push_i,
   input wire logic [rjlc_pkg::FRAME_W-1:0] stack_frame_i,
   output logic [rjlc_pkg::DATA_W-1:0] reg_data_o,
   output logic [rjlc_pkg::ADDR_W-1:0] word2_o,
   output logic [7:0] push_count_o,
   output logic [rjlc_pkg::FRAME_W-1:0] top_frame_o
);
   import rjlc_pkg::*;
   localparam logic [ADDR_W-1:0] WORD_KEY = 16'hC3A5;
   logic [DATA_W-1:0] regs [32];
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         reg_data_o <= 8'h00;
         word2_o <= 16'h0000;
         push_count_o <= 8'h00;
         top_frame_o <= '0;
      end else begin
         // data held one cycle, then inverted on every cycle while released
         reg_data_o <= reg_rd_i ? regs[reg_sel_i] : ~reg_data_o;
         word2_o <= word2_req_i ? (word2_addr_i ^ WORD_KEY) : ~word2_o;
         if (stack_push_i) begin
            push_count_o <= push_count_o + 8'h01;
            top_frame_o <= stack_frame_i;
         end
      end
   end
endmodule // rjlc_far

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
   import rjlc_pkg::*;
   logic clk_sys_i = 1'b0, reset_i = 1'b1, start_i = 1'b0;
   logic [15:0] instr_i = 16'h0000, next_pc_i = 16'h0000, word2_i, word2_addr_o, pc_o;
   logic [DATA_W-1:0] reg_data_i;
   logic [FLAG_W-1:0] alu_flags_i = 4'h0;
   logic global_interrupt_enable_i = 1'b0, bank_a_alt_i = 1'b0, bank_b_alt_i = 1'b0;
   logic busy_o, reg_rd_o, word2_req_o, pc_load_o, stack_push_o, flags_we_o, illegal_o;
   logic [SRC_W-1:0] reg_sel_o;
   logic [FRAME_W-1:0] stack_frame_o, top_frame;
   logic [7:0] push_count;
   int err_total = 0, n_compared = 0;
   always #2.5 clk_sys_i = ~clk_sys_i;
   rjlc_unit #(.PC_W(16)) i_rjlc_unit (.clk_sys_i, .reset_i, .start_i, .instr_i, .next_pc_i, .reg_data_i,
      .word2_i, .alu_flags_i, .global_interrupt_enable_i, .bank_a_alt_i, .bank_b_alt_i, .busy_o, .reg_sel_o,
      .reg_rd_o, .word2_req_o, .word2_addr_o, .pc_load_o, .pc_o, .stack_push_o, .stack_frame_o, .flags_we_o,
      .illegal_o);
   rjlc_far i_rjlc_far (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_sel_i(reg_sel_o), .reg_rd_i(reg_rd_o),
      .word2_req_i(word2_req_o), .word2_addr_i(word2_addr_o), .stack_push_i(stack_push_o),
      .stack_frame_i(stack_frame_o), .reg_data_o(reg_data_i), .word2_o(word2_i), .push_count_o(push_count),
      .top_frame_o(top_frame));
   // ***************************************************************
   // shared tasks
   // ***************************************************************
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic exec(input logic [15:0] ins, input logic [15:0] npc, output int lat, output logic push);
      @(posedge clk_sys_i);
      start_i <= 1'b1;
      instr_i <= ins;
      next_pc_i <= npc;
      @(posedge clk_sys_i);
      start_i <= 1'b0;
      lat = 0;
      push = 1'b0;
      for (int n = 1; n <= 12 && lat == 0; n++) begin
         @(posedge clk_sys_i);
         #1;
         if (pc_load_o === 1'b1) begin
            lat = n + 1;
            push = stack_push_o;
         end
      end
      chk("flags_we", flags_we_o, 1'b0);
   endtask
   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic t_jmp;
      logic [7:0] d [5] = '{8'h7F, 8'h80, 8'h00, 8'hFF, 8'h01};
      int lat;
      logic push;
      for (int i = 0; i < 5; i++) begin
         exec({8'hCB, d[i]}, 16'h0040 + 16'(i), lat, push);
         chk("jimm_pc", pc_o, 16'(16'h0040 + 16'(i) + {{8{d[i][7]}}, d[i]}));
         chk("jimm_lat", lat, 3);
         chk("jimm_push", push, 1'b0);
      end
      for (int i = 0; i < 2; i++) begin
         i_rjlc_far.regs[5'd3 + 5'(i * 28)] = d[i];
         exec({8'hCD, 3'b100, 5'd3 + 5'(i * 28)}, 16'h8000, lat, push);
         chk("jreg_pc", pc_o, 16'(16'h8000 + {{8{d[i][7]}}, d[i]}));
         chk("jreg_lat", lat, 4);
         chk("jreg_sel", reg_sel_o, 5'd3 + 5'(i * 28));
      end
      $display("test relative jumps done");
   endtask
   task automatic t_rmk;
      logic [7:0] v [5] = '{8'hB5, 8'hB5, 8'h6D, 8'hFF, 8'h81};
      logic [2:0] b [5] = '{3'd0, 3'd1, 3'd7, 3'd3, 3'd0};
      logic [2:0] m [5] = '{3'd0, 3'd4, 3'd2, 3'd7, 3'd1};
      logic [15:0] r;
      int lat;
      logic push;
      for (int i = 0; i < 5; i++) begin
         i_rjlc_far.regs[16 + i] = v[i];
         r = {v[i], v[i]} >> b[i];
         r[7:0] = r[7:0] & (8'hFF >> m[i]) & 8'hFE;
         exec({5'b10011, m[i], b[i], 5'(16 + i)}, 16'h2000, lat, push);
         chk("rmk_pc", pc_o, 16'(16'h2000 + {{8{r[7]}}, r[7:0]}));
         chk("rmk_src", i_rjlc_far.regs[16 + i], v[i]);
         chk("rmk_lat", lat, 4);
      end
      $display("test rotate mask jump done");
   endtask
   task automatic t_call;
      logic [15:0] npc;
      logic [7:0] cnt;
      logic taken;
      int lat;
      logic push;
      i_rjlc_far.regs[9] = 8'h24;
      for (int i = 0; i < 17; i++) begin
         npc = 16'h0100 * 16'(i) + 16'h0011;
         cnt = push_count;
         taken = (i == 16) || (i[0] == i_rjlc_far.regs[9][i[3:1]]);
         alu_flags_i <= {1'b1, i[3:1]};
         global_interrupt_enable_i <= i[1];
         bank_a_alt_i <= i[2];
         bank_b_alt_i <= i[3];
         if (i == 16) exec(16'hCE00, 16'hFFFE, lat, push);
         else exec({7'b1000100, i[0], i[3:1], 5'd9}, npc, lat, push);
         if (i == 16) npc = 16'hFFFE;
         // stack model takes the frame one edge after the push
         @(posedge clk_sys_i);
         #1;
         chk("call_addr", word2_addr_o, npc);
         chk("call_pc", pc_o, taken ? (npc ^ 16'hC3A5) : npc + 16'h0001);
         chk("call_push", push, taken);
         chk("call_count", push_count, cnt + 8'(taken));
         chk("call_lat", lat, 4);
         if (taken) chk("call_frame", top_frame, {npc + 16'h0001, 1'b1, i[3:1], i[1], i[2], i[3]});
      end
      $display("test long calls done");
   endtask
   task automatic t_illegal;
      int lat;
      logic push;
      @(posedge clk_sys_i);
      start_i <= 1'b1;
      instr_i <= 16'h0000;
      @(posedge clk_sys_i);
      start_i <= 1'b0;
      #1;
      chk("ill_flag", illegal_o, 1'b1);
      chk("ill_busy", busy_o, 1'b0);
      exec(16'hCB10, 16'h0300, lat, push);
      chk("ill_next", pc_o, 16'h0310);
      $display("test unknown opcode done");
   endtask
   // ***************************************************************
   // main sequence and watchdog
   // ***************************************************************
   initial begin
      repeat (10) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      t_jmp();
      t_rmk();
      t_call();
      t_illegal();
      test_done();
   end
   initial begin
      #20000;
      err_total++;
      $display("Error watchdog expected finish seen hang");
      test_done();
   end
endmodule // tb
